// file: logic/warmup_pkg.sv
// Package with register map, field layout and shared types for the warm-up counter
package warmup_pkg;
  localparam logic [11:0] OFS_COMPARE   = 12'h000;
  localparam logic [11:0] OFS_CONTROL   = 12'h004;
  localparam logic [11:0] OFS_OSC       = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;
  localparam logic [7:0]  COMPARE_RST   = 8'h66;
  localparam logic        SEL_RST       = 1'h0;
  localparam logic [1:0]  DIV_RST       = 2'h3;
  localparam int          CNT_W         = 14;
  localparam int          CMP_W         = 8;
  localparam int          CTL_SEL_BIT   = 0;
  localparam int          CTL_DIV_LSB   = 1;
  localparam int          CTL_ABORT_BIT = 3;
  localparam int          OSC_HF_BIT    = 0;
  localparam int          OSC_LF_BIT    = 1;
  localparam logic [1:0]  SYNC_RST      = 2'h0;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_IDLE  = 3'h1,
    ST_SW    = 3'h2,
    ST_STOP  = 3'h3,
    ST_WAKE  = 3'h4
  } wu_state_t;

  typedef struct packed {
    logic [7:0] compare;
    logic       sel;
    logic [1:0] div;
  } wu_cfg_t;

  typedef struct packed {
    logic       hf;
    logic       lf;
  } osc_en_t;
endpackage : warmup_pkg

// file: logic/warmup_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse on the synchronised level
module warmup_edge_sync (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic din,      // Asynchronous level
  output logic      level,    // Synchronised level
  output logic      rise      // One-cycle pulse on rising edge
);
  typedef struct packed {
    logic [1:0] sync;
    logic       last;
  } sync_state_t;
  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sync = {st_ff.sync[0], din};
    nxt_st.last = st_ff.sync[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Only the second stage feeds logic
  assign level = st_ff.sync[1];
  assign rise  = st_ff.sync[1] & ~st_ff.last;
endmodule : warmup_edge_sync

// file: logic/warmup_divider.sv
// Three-stage source divider producing a one-cycle counter enable
module warmup_divider (
  input  wire logic       pclk,     // System clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic       clr,      // Synchronous clear of the divider
  input  wire logic       src_tick, // One pulse per source clock edge
  input  wire logic [1:0] div,      // Divide select
  output logic            cnt_en    // Counter increment enable
);
  typedef struct packed {
    logic [2:0] stage;
  } div_state_t;
  div_state_t st_ff;
  div_state_t nxt_st;
  logic [2:0] mask;

  always_comb begin
    mask   = 3'((4'h1 << div) - 4'h1);
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.stage = '0;
    end else if (src_tick) begin
      nxt_st.stage = st_ff.stage + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Enable when all lower stages roll over
  assign cnt_en = src_tick & ~clr & ((st_ff.stage & mask) == mask);
endmodule : warmup_divider

// file: logic/warmup_counter.sv
// Oscillator warm-up counter with APB register access
// Functional notes
// - POR release frees counter, core held reset
// - Reset sets source 0, divide 11
// - After POR, count high-frequency clock edges
// - POR match halts count, releases core reset
// - Compare value resets to 0x66
// - STOP wake counts clock running at entry
// - STOP release starts counting divided clock
// - Wake match halts count, resumes execution
// - Divide select gives /1 /2 /4 /8
// - STOP during software warm-up holds count
// - Enable bit start launches oscillator and count
// - Software match raises interrupt, clears counter
// - Abort stops, clears counter, self-clears
// - Abort leaves oscillator enables unchanged
// - Only enable rising edge starts counting
// - Wake completion clears prescaler chain
//
// Decided for this implementation: the APB slave port and the register addresses.
module warmup_counter (
  input  wire logic        pclk,           // System clock, 200 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        high_freq_clock,// Raw high-frequency oscillator output
  input  wire logic        low_freq_clock, // Raw low-frequency oscillator output
  input  wire logic        stop_req,       // STOP mode entry request, level
  input  wire logic        stop_release,   // STOP release event, level
  input  wire logic        main_clk_lf,    // Main system clock runs from low-freq clock
  output logic             core_resetn,    // CPU and peripheral reset, active low
  output logic             resume,         // Pulse: execution resumes after STOP
  output logic             prescaler_clr,  // Pulse: clear prescaler and divider chain
  output logic             warmup_done_irq,// Pulse: software warm-up done
  output logic             hf_osc_en,      // High-frequency oscillator enable
  output logic             lf_osc_en,      // Low-frequency oscillator enable
  output logic             in_stop         // Device held in STOP
);
  typedef struct packed {
    warmup_pkg::wu_state_t  state;
    warmup_pkg::wu_state_t  held;
    warmup_pkg::wu_cfg_t    cfg;
    warmup_pkg::osc_en_t    osc;
    logic                   wake_lf;
    logic [13:0]            count;
    logic                   core_rstn;
    logic                   resume;
    logic                   pclr;
    logic                   irq;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
    logic                   stopped;
  } wu_top_t;

  wu_top_t st_ff;
  wu_top_t nxt_st;

  logic hf_lvl;
  logic hf_rise;
  logic lf_lvl;
  logic lf_rise;
  logic stop_lvl;
  logic rel_lvl;
  logic rel_rise;
  logic lf_main_lvl;
  logic src_tick;
  logic div_clr;
  logic cnt_en;
  logic [1:0] div_eff;

  warmup_edge_sync u_hf (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (high_freq_clock),
    .level   (hf_lvl),
    .rise    (hf_rise)
  );
  warmup_edge_sync u_lf (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (low_freq_clock),
    .level   (lf_lvl),
    .rise    (lf_rise)
  );
  warmup_edge_sync u_stop (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (stop_req),
    .level   (stop_lvl),
    .rise    ()
  );
  warmup_edge_sync u_rel (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (stop_release),
    .level   (rel_lvl),
    .rise    (rel_rise)
  );
  warmup_edge_sync u_mclk (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (main_clk_lf),
    .level   (lf_main_lvl),
    .rise    ()
  );

  // Upper count bits against compare value
  // A compare value of zero matches on the first count step
  function automatic logic cmp_hit(input logic [13:0] cnt, input logic [7:0] cmp);
    cmp_hit = (cnt[warmup_pkg::CNT_W-1 -: warmup_pkg::CMP_W] == cmp);
  endfunction : cmp_hit

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // wake source choice
  // Wake uses the clock latched at STOP entry, select field ignored
  always_comb begin
    case (st_ff.state)
      warmup_pkg::ST_STOP,
      warmup_pkg::ST_WAKE: begin
        src_tick = st_ff.wake_lf ? lf_rise : hf_rise;
      end
      warmup_pkg::ST_SW: begin
        src_tick = st_ff.cfg.sel ? lf_rise : hf_rise;
      end
      default: begin
        src_tick = hf_rise;
      end
    endcase
  end

  // divide rate
  // Power-on wait always uses the reset divide setting
  assign div_eff = (st_ff.state == warmup_pkg::ST_POR) ? warmup_pkg::DIV_RST : st_ff.cfg.div;

  // Divider is cleared at each start so the first divided period is whole
  warmup_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (div_clr),
    .src_tick (src_tick),
    .div      (div_eff),
    .cnt_en   (cnt_en)
  );

  always_comb begin
    logic       wr;
    logic       rd;
    logic       hit;
    logic [1:0] osc_new;
    wr          = 1'b0;
    rd          = 1'b0;
    hit         = 1'b0;
    osc_new     = '0;
    nxt_st      = st_ff;
    nxt_st.resume = 1'b0;
    nxt_st.pclr   = 1'b0;
    nxt_st.irq    = 1'b0;
    nxt_st.ready  = 1'b0;
    nxt_st.err    = 1'b0;
    div_clr       = 1'b0;

    // One wait state: access phase answered the cycle after penable rises
    // Writes land on the first access edge, the same edge that raises pready
    if (psel && penable && !st_ff.ready) begin
      nxt_st.ready = 1'b1;
      wr = pwrite;
      rd = !pwrite;
      nxt_st.err = !(addr_is(paddr, warmup_pkg::OFS_COMPARE) ||
                     addr_is(paddr, warmup_pkg::OFS_CONTROL) ||
                     addr_is(paddr, warmup_pkg::OFS_OSC) ||
                     addr_is(paddr, warmup_pkg::OFS_STATUS));
    end

    if (rd) begin
      nxt_st.rdata = '0;
      if (addr_is(paddr, warmup_pkg::OFS_COMPARE)) begin
        nxt_st.rdata[7:0] = st_ff.cfg.compare;
      end else if (addr_is(paddr, warmup_pkg::OFS_CONTROL)) begin
        nxt_st.rdata[warmup_pkg::CTL_SEL_BIT] = st_ff.cfg.sel;
        nxt_st.rdata[warmup_pkg::CTL_DIV_LSB +: 2] = st_ff.cfg.div;
      end else if (addr_is(paddr, warmup_pkg::OFS_OSC)) begin
        nxt_st.rdata[warmup_pkg::OSC_HF_BIT] = st_ff.osc.hf;
        nxt_st.rdata[warmup_pkg::OSC_LF_BIT] = st_ff.osc.lf;
      end else if (addr_is(paddr, warmup_pkg::OFS_STATUS)) begin
        nxt_st.rdata[13:0]  = st_ff.count;
        nxt_st.rdata[18:16] = st_ff.state;
      end
    end

    if (wr && addr_is(paddr, warmup_pkg::OFS_COMPARE)) begin
      nxt_st.cfg.compare = pwdata[7:0];
    end
    if (wr && addr_is(paddr, warmup_pkg::OFS_CONTROL)) begin
      nxt_st.cfg.sel = pwdata[warmup_pkg::CTL_SEL_BIT];
      nxt_st.cfg.div = pwdata[warmup_pkg::CTL_DIV_LSB +: 2];
    end

    // Counting runs on the divided enable
    if (cnt_en) begin
      nxt_st.count = st_ff.count + 14'h1;
    end

    case (st_ff.state)
      warmup_pkg::ST_POR: begin
        nxt_st.core_rstn = 1'b0;
        if (cnt_en && cmp_hit(nxt_st.count, st_ff.cfg.compare)) begin
          nxt_st.core_rstn = 1'b1;
          nxt_st.count     = '0;
          nxt_st.state     = warmup_pkg::ST_IDLE;
        end
      end
      warmup_pkg::ST_SW: begin
        if (cnt_en && cmp_hit(nxt_st.count, st_ff.cfg.compare)) begin
          nxt_st.irq   = 1'b1;
          nxt_st.count = '0;
          nxt_st.state = warmup_pkg::ST_IDLE;
        end
      end
      warmup_pkg::ST_STOP: begin
        nxt_st.count = st_ff.count;
        div_clr      = 1'b1;
        if (rel_rise) begin
          nxt_st.state = warmup_pkg::ST_WAKE;
        end
      end
      warmup_pkg::ST_WAKE: begin
        // wake match resumes and clears chain
        if (cnt_en && cmp_hit(nxt_st.count, st_ff.cfg.compare)) begin
          nxt_st.resume = 1'b1;
          nxt_st.pclr   = 1'b1;
          nxt_st.count  = '0;
          // Back to a software warm-up, which restarts from zero
          nxt_st.state  = (st_ff.held == warmup_pkg::ST_SW) ? warmup_pkg::ST_SW
                                                             : warmup_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st.count = '0;
      end
    endcase

    // STOP entry from a running state latches the main clock source
    // A kept software count shortens the wake wait; software must avoid it
    if (stop_lvl && (st_ff.state == warmup_pkg::ST_IDLE || st_ff.state == warmup_pkg::ST_SW)) begin
      nxt_st.held    = st_ff.state;
      nxt_st.wake_lf = lf_main_lvl;
      nxt_st.state   = warmup_pkg::ST_STOP;
      if (st_ff.state == warmup_pkg::ST_IDLE) begin
        nxt_st.count = '0;
      end else begin
        nxt_st.count = st_ff.count;
      end
    end

    // abort does not touch the enable bits
    if (wr && addr_is(paddr, warmup_pkg::OFS_OSC)) begin
      osc_new[0] = pwdata[warmup_pkg::OSC_HF_BIT];
      osc_new[1] = pwdata[warmup_pkg::OSC_LF_BIT];
      nxt_st.osc.hf = osc_new[0];
      nxt_st.osc.lf = osc_new[1];
      hit = (osc_new[0] & ~st_ff.osc.hf) | (osc_new[1] & ~st_ff.osc.lf);
      // STOP entry in the same cycle wins over a start
      if (hit && st_ff.state == warmup_pkg::ST_IDLE
          && !stop_lvl) begin
        nxt_st.count = '0;
        nxt_st.state = warmup_pkg::ST_SW;
        div_clr      = 1'b1;
      end
    end

    // abort clears count; bit is never stored so reads 0
    // A match pulse raised in the same cycle still goes out
    if (wr && addr_is(paddr, warmup_pkg::OFS_CONTROL) && pwdata[warmup_pkg::CTL_ABORT_BIT]
        && st_ff.state == warmup_pkg::ST_SW) begin
      nxt_st.count = '0;
      nxt_st.state = warmup_pkg::ST_IDLE;
      div_clr      = 1'b1;
    end

    // Output flop for the STOP indication
    nxt_st.stopped = (nxt_st.state == warmup_pkg::ST_STOP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.state       <= warmup_pkg::ST_POR;
      st_ff.held        <= warmup_pkg::ST_IDLE;
      st_ff.cfg.compare <= warmup_pkg::COMPARE_RST;
      st_ff.cfg.sel     <= warmup_pkg::SEL_RST;
      st_ff.cfg.div     <= warmup_pkg::DIV_RST;
      // Fast oscillator runs from reset for the power-on wait
      st_ff.osc.hf      <= 1'b1;
      st_ff.osc.lf      <= 1'b0;
      st_ff.wake_lf     <= 1'b0;
      st_ff.count       <= '0;
      st_ff.core_rstn   <= 1'b0;
      st_ff.resume      <= 1'b0;
      st_ff.pclr        <= 1'b0;
      st_ff.irq         <= 1'b0;
      st_ff.rdata       <= '0;
      st_ff.ready       <= 1'b0;
      st_ff.err         <= 1'b0;
      st_ff.stopped     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a bit of the registered state
  assign prdata          = st_ff.rdata;
  assign pready          = st_ff.ready;
  assign pslverr         = st_ff.err;
  assign core_resetn     = st_ff.core_rstn;
  assign resume          = st_ff.resume;
  assign prescaler_clr   = st_ff.pclr;
  assign warmup_done_irq = st_ff.irq;
  assign hf_osc_en       = st_ff.osc.hf;
  assign lf_osc_en       = st_ff.osc.lf;
  assign in_stop         = st_ff.stopped;
endmodule : warmup_counter

// file: verification/osc_model.sv
// Oscillator partner model: raw clocks that stop when disabled or in STOP
module osc_model #(
  parameter int HF_PERIOD = 2, // Edge-aligned, so half rate loses no edge
  parameter int LF_PERIOD = 4
) (
  input  wire logic pclk,   // Clock
  input  wire logic hf_en,  // High-freq enable
  input  wire logic lf_en,  // Low-freq enable
  input  wire logic halt,   // STOP stops every oscillator
  output logic      hf_clk, // Raw high-freq clock
  output logic      lf_clk  // Raw low-freq clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int   hf_ph = 0;
  int   lf_ph = 0;
  logic hf_run;
  logic lf_run;
  assign hf_run = hf_en === 1'h1 && halt !== 1'h1;
  assign lf_run = lf_en === 1'h1 && halt !== 1'h1;
  // Raw output, no grace before the first edge
  always @(posedge pclk) begin
    hf_ph  <= hf_run ? (hf_ph + 1) % HF_PERIOD : 0;
    lf_ph  <= lf_run ? (lf_ph + 1) % LF_PERIOD : 0;
    hf_clk <= hf_run && hf_ph == HF_PERIOD - 1;
    lf_clk <= lf_run && lf_ph == LF_PERIOD - 1;
  end
endmodule : osc_model

// file: verification/warmup_counter_checker.sv
// Port checker for the warm-up counter
module warmup_counter_checker (
  input wire logic        pclk,            // Clock
  input wire logic        presetn,         // Reset
  input wire logic        psel,            // APB
  input wire logic        penable,         // APB
  input wire logic        pwrite,          // APB
  input wire logic [11:0] paddr,           // APB
  input wire logic [31:0] pwdata,          // APB
  input wire logic [31:0] prdata,          // APB
  input wire logic        pready,          // APB
  input wire logic        pslverr,         // APB
  input wire logic        high_freq_clock, // Raw clock
  input wire logic        low_freq_clock,  // Raw clock
  input wire logic        stop_req,        // STOP request
  input wire logic        stop_release,    // STOP release
  input wire logic        main_clk_lf,     // Main clock source
  input wire logic        core_resetn,     // Core reset
  input wire logic        resume,          // Wake done
  input wire logic        prescaler_clr,   // Chain clear
  input wire logic        warmup_done_irq, // Done pulse
  input wire logic        hf_osc_en,       // Enable
  input wire logic        lf_osc_en,       // Enable
  input wire logic        in_stop          // In STOP
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  bad_addr_a: assert property (acc && paddr > warmup_pkg::OFS_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  por_hold_a: assert property (!core_resetn |-> !warmup_done_irq && !resume)
    else $error("activity while core held");
  core_keep_a: assert property (core_resetn |=> core_resetn)
    else $error("core reset asserted again");
  irq_pulse_a: assert property (warmup_done_irq |=> !warmup_done_irq)
    else $error("done pulse too long");
  wake_clear_a: assert property (resume == prescaler_clr)
    else $error("chain clear not with resume");
  resume_once_a: assert property (resume |-> !in_stop ##1 !resume)
    else $error("bad resume pulse");
  stop_quiet_a: assert property (in_stop |-> !warmup_done_irq && !resume)
    else $error("completion during STOP");
  abort_keep_a: assert property (acc && pwrite && paddr == warmup_pkg::OFS_CONTROL
    && pwdata[3] |-> $stable({hf_osc_en, lf_osc_en})) else $error("abort moved enables");
  irq_c: cover property (warmup_done_irq);
  resume_c: cover property (resume);
  err_c: cover property (acc && pslverr);
endmodule : warmup_counter_checker

bind warmup_counter warmup_counter_checker u_warmup_counter_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .high_freq_clock(high_freq_clock), .low_freq_clock(low_freq_clock), .stop_req(stop_req),
  .stop_release(stop_release), .main_clk_lf(main_clk_lf), .core_resetn(core_resetn),
  .resume(resume), .prescaler_clr(prescaler_clr), .warmup_done_irq(warmup_done_irq),
  .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en), .in_stop(in_stop));

// file: verification/oscillator_warmup_counter_test.sv
// Self-checking bench for the warm-up counter
module oscillator_warmup_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        stop_req = 0, stop_release = 0, main_clk_lf = 0, pready, pslverr;
  logic        high_freq_clock, low_freq_clock, core_resetn, resume, prescaler_clr;
  logic        warmup_done_irq, hf_osc_en, lf_osc_en, in_stop;
  int          fail_count = 0, tests_run = 0, hf_edges = 0, lf_edges = 0, base = 0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    hf_edges <= hf_edges + high_freq_clock;
    lf_edges <= lf_edges + low_freq_clock;
  end

  warmup_counter u_warmup_counter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_freq_clock(high_freq_clock), .low_freq_clock(low_freq_clock), .stop_req(stop_req),
    .stop_release(stop_release), .main_clk_lf(main_clk_lf), .core_resetn(core_resetn),
    .resume(resume), .prescaler_clr(prescaler_clr), .warmup_done_irq(warmup_done_irq),
    .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en), .in_stop(in_stop));
  osc_model u_osc_model (.pclk(pclk), .hf_en(hf_osc_en), .lf_en(lf_osc_en), .halt(stop_req),
    .hf_clk(high_freq_clock), .lf_clk(low_freq_clock));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic int exp_edges(input logic [7:0] cmp, input logic [1:0] dv);
    return cmp * (64 << dv);
  endfunction : exp_edges

  // Synchroniser latency shifts the count by a few source edges
  function automatic int near(input int seen, input int exp);
    return (seen >= exp - 1 && seen <= exp + 4) ? exp : seen;
  endfunction : near

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    check("wait states", n, 32'h2);
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'h1, a, v, d, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'h0, a, 32'h0, d, e);
  endtask : rd

  // Which: 0 done pulse, 1 resume, 2 core released, 3 in STOP
  task automatic wait_sig(input int which, input int lim, output logic got);
    got = 0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge pclk);
      got = (which == 0) ? warmup_done_irq === 1'h1 : (which == 1) ? resume === 1'h1 :
            (which == 2) ? core_resetn === 1'h1 : in_stop === 1'h1;
    end
  endtask : wait_sig

  task automatic sw_start(input logic sel, input logic [1:0] dv, input logic [7:0] cmp);
    // Source, rate and time set before the enable
    wr(warmup_pkg::OFS_COMPARE, {24'h0, cmp});
    wr(warmup_pkg::OFS_CONTROL, {29'h0, dv, sel});
    // Enable cleared first so the next write is a rising edge
    wr(warmup_pkg::OFS_OSC, sel ? 32'h1 : 32'h0);
    base = sel ? lf_edges : hf_edges;
    wr(warmup_pkg::OFS_OSC, sel ? 32'h3 : 32'h1);
  endtask : sw_start

  task automatic sw_finish(input logic sel, input logic [1:0] dv, input logic [7:0] cmp);
    int e;
    logic got;
    logic [31:0] d;
    e = exp_edges(cmp, dv);
    wait_sig(0, e * 6 + 100, got);
    check("sw done", got, 1'h1);
    check("sw edges", near((sel ? lf_edges : hf_edges) - base, e), e);
    rd(warmup_pkg::OFS_STATUS, d);
    check("count cleared", d[13:0], 14'h0);
  endtask : sw_finish

  initial begin
    #700000;
    fail_count++;
    give_verdict();
  end

  initial begin
    logic got;
    logic [31:0] d, d2;
    presetn = 0;
    void'($urandom(32'hFC31CB5C));
    repeat (8) @(posedge pclk);
    check("core held", core_resetn, 1'h0);
    presetn <= 1'h1;
    base = hf_edges;
    @(posedge pclk);
    rd(warmup_pkg::OFS_COMPARE, d);
    check("compare reset", d, 32'h66);
    rd(warmup_pkg::OFS_CONTROL, d);
    check("control reset", d, 32'h6);
    rd(warmup_pkg::OFS_OSC, d);
    check("osc reset", d, 32'h1);
    apb(1'h0, 12'h010, 32'h0, d, got);
    check("unmapped err", got, 1'h1);
    check("unmapped data", d, 32'h0);
    wait_sig(2, 110000, got);
    check("core release", got, 1'h1);
    d = exp_edges(warmup_pkg::COMPARE_RST, warmup_pkg::DIV_RST);
    check("por edges", near(hf_edges - base, d), d);
    for (int i = 0; i < 4; i++) begin
      d = 1 + $urandom % 2;
      sw_start(i[0], i[1:0], d[7:0]);
      sw_finish(i[0], i[1:0], d[7:0]);
    end
    wr(warmup_pkg::OFS_OSC, 32'h3);
    wait_sig(0, 600, got);
    check("one over one", got, 1'h0);
    rd(warmup_pkg::OFS_STATUS, d);
    check("one over one state", d[18:16], warmup_pkg::ST_IDLE);
    sw_start(1'h1, 2'h0, 8'h10);
    repeat (100) @(posedge pclk);
    wr(warmup_pkg::OFS_CONTROL, 32'h9);
    rd(warmup_pkg::OFS_CONTROL, d);
    check("abort self clear", d, 32'h1);
    rd(warmup_pkg::OFS_STATUS, d);
    check("abort cleared", d[18:0], 19'h10000);
    rd(warmup_pkg::OFS_OSC, d);
    check("abort enables", d, 32'h3);
    wait_sig(0, 600, got);
    check("abort quiet", got, 1'h0);
    sw_start(1'h1, 2'h0, 8'h1);
    sw_finish(1'h1, 2'h0, 8'h1);
    for (int m = 0; m < 2; m++) begin
      wr(warmup_pkg::OFS_COMPARE, 32'h1);
      wr(warmup_pkg::OFS_CONTROL, {31'h0, ~m[0]});
      main_clk_lf <= m[0];
      stop_req <= 1'h1;
      wait_sig(3, 20, got);
      check("stop entered", got, 1'h1);
      repeat (20) @(posedge pclk);
      stop_req <= 1'h0;
      stop_release <= 1'h1;
      base = m ? lf_edges : hf_edges;
      wait_sig(1, 600, got);
      check("resume", got, 1'h1);
      check("wake edges", near((m ? lf_edges : hf_edges) - base, 64), 64);
      stop_release <= 1'h0;
    end
    sw_start(1'h1, 2'h0, 8'h2);
    repeat (200) @(posedge pclk);
    // STOP in mid warm-up on purpose, to see the count held
    stop_req <= 1'h1;
    wait_sig(3, 20, got);
    rd(warmup_pkg::OFS_STATUS, d);
    repeat (40) @(posedge pclk);
    rd(warmup_pkg::OFS_STATUS, d2);
    check("stop hold", d2[13:0], d[13:0]);
    check("stop count kept", d[13:0] != 14'h0, 1'h1);
    stop_req <= 1'h0;
    stop_release <= 1'h1;
    wait_sig(0, 4000, got);
    check("sw after wake", got, 1'h1);
    stop_release <= 1'h0;
    give_verdict();
  end
endmodule : oscillator_warmup_counter_test
